/* File: sfcs_consts.svh */
// Purpose: Constants of the serial flash command sequencer.
// Assumes: 100 MHz system clock, single-lane SPI mode 0 flash.
// Notes:   Included by the sequencer file.
// How it works
// R01: Boot sends latch enable, polls status until latch flag, then stores zero status.
// R02: Every program or erase is preceded by latch enable and latch flag polling.
// R03: Flash clears its latch after each program or erase; enable is always repeated.
// R04: Identification signature is never read; opcodes and clock rate are fixed.
// R05: Fast read is opcode, three address bytes MSB first, dummy, streaming data.
// R06: Status store sends opcode and exactly one status byte, never a second.
// R07: Page program is opcode, three address bytes, then data while select stays low.
// R08: Sector erase is opcode plus three address bytes; chip erase is opcode only.
// R09: Flash hold and write-protect inputs are never driven by this block.
// R10: During reset, serial clock, data out and flash select float; second select stays driven.
// R11: Floating pins during reset let an external programmer own the flash.
// R12: Status bit 0 is write pending, bit 1 is write latch.
// R13: Protection clearing is always done at boot, whatever flash is attached.
// R14: SPI mode 0, MSB first, select low for a whole command, high between.
// R15: After program or erase, poll write pending until clear before next command.
`ifndef SFCS_CONSTS_SVH
`define SFCS_CONSTS_SVH

`define SFCS_LATCH_ENABLE_COMMAND   8'h06
`define SFCS_STATUS_FETCH_COMMAND   8'h05
`define SFCS_STATUS_STORE_COMMAND   8'h01
`define SFCS_FAST_READ_COMMAND      8'h0b
`define SFCS_PAGE_PROGRAM_COMMAND   8'h02
`define SFCS_SECTOR_ERASE_COMMAND   8'h20
`define SFCS_CHIP_ERASE_COMMAND     8'hc7
`define SFCS_STATUS_CLEAR_VALUE     8'h00
`define SFCS_DUMMY_BYTE             8'h00
`define SFCS_WRITE_PENDING_FLAG_BIT 0
`define SFCS_WRITE_LATCH_FLAG_BIT   1

`define SFCS_CLOCK_PERIOD_NS   10
`define SFCS_SCK_MIN_PERIOD_NS 705
`define SFCS_SCK_HALF_CYCLES   ((`SFCS_SCK_MIN_PERIOD_NS + 2 * `SFCS_CLOCK_PERIOD_NS - 1) / (2 * `SFCS_CLOCK_PERIOD_NS))
`define SFCS_CS_HIGH_NS        200
`define SFCS_CS_HIGH_CYCLES    ((`SFCS_CS_HIGH_NS + `SFCS_CLOCK_PERIOD_NS - 1) / `SFCS_CLOCK_PERIOD_NS)

`define SFCS_FIFO_WIDTH 8
`define SFCS_FIFO_DEPTH 32

`endif

/* File: sfcs_pkg.sv */
// Purpose: Types of the serial flash command sequencer.
// Assumes: Nothing beyond the constants header.
// Notes:   Operation codes on i_cmd_op follow the order of sfcs_op_e.
package sfcs_pkg;
  typedef enum logic [1:0] {
    OP_READ,
    OP_PROGRAM,
    OP_SECTOR_ERASE,
    OP_CHIP_ERASE
  } sfcs_op_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LATCH_ENABLE_COMMAND,
    ST_POLL_WEL,
    ST_MAIN,
    ST_POLL_WIP
  } sfcs_state_e;
endpackage

/* File: sfcs_sequencer.sv */
// Purpose: Serial NOR flash command sequencer with program data FIFO.
// Assumes: One 100 MHz clock, synchronous active-high reset, flash data in is asynchronous.
// Notes:   The serial clock is produced from the system clock; flash hold and write-protect are not ports.
`timescale 1ns/1ns
`default_nettype none
`include "sfcs_consts.svh"

module sfcs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             rdy_q, rdy_d, vld_q, vld_d, push, pop;

  always_comb begin
    push  = i_in_valid && rdy_q;
    pop   = i_out_ready && vld_q;
    wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = (AW + 1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    rdy_d = cnt_d != (AW + 1)'(DEPTH);
    vld_d = cnt_d != '0;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
      vld_q <= 1'b0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
      vld_q <= vld_d;
    end
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  assign o_in_ready  = rdy_q;
  assign o_out_valid = vld_q;
  assign o_out_data  = mem_q[rd_q];
endmodule

module sfcs_sequencer
  import sfcs_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_cmd_valid,
  input  wire logic [1:0]  i_cmd_op,
  input  wire logic [23:0] i_cmd_addr,
  input  wire logic [15:0] i_cmd_len,
  output logic             o_cmd_ready,
  output logic             o_boot_done,
  input  wire logic        i_wr_valid,
  input  wire logic [7:0]  i_wr_data,
  output logic             o_wr_ready,
  output logic             o_rd_valid,
  output logic [7:0]       o_rd_data,
  output logic             o_flash_serial_clock,
  output logic             o_flash_serial_clock_oe,
  output logic             o_flash_serial_out,
  output logic             o_flash_serial_out_oe,
  output logic             o_flash_select_n,
  output logic             o_flash_select_n_oe,
  output logic             o_second_device_select_n,
  input  wire logic        i_flash_serial_in
);
  localparam logic [5:0] HALF_LAST = 6'(`SFCS_SCK_HALF_CYCLES - 1);
  localparam logic [4:0] GAP_LEN   = 5'(`SFCS_CS_HIGH_CYCLES);

  sfcs_state_e st_q, st_d;
  sfcs_op_e    op_q, op_d;
  logic [23:0] addr_q, addr_d;
  logic [15:0] len_q, len_d;
  logic [16:0] nbytes_q, nbytes_d, byte_q, byte_d, nxt;
  logic [7:0]  tx_q, tx_d, rx_q, rx_d, status_q, status_d, rd_data_q, rd_data_d, nxt_byte;
  logic [5:0]  half_q, half_d;
  logic [4:0]  gap_q, gap_d;
  logic [2:0]  bit_q, bit_d;
  logic        act_q, act_d, sck_q, sck_d, cs_q, cs_d, oe_q;
  logic        boot_q, boot_d, booted_q, booted_d, ready_q, ready_d, rd_valid_q, rd_valid_d;
  logic        sin_meta_q, sin_q, start, done, need_data, byte_end, fifo_pop, fifo_valid;
  logic [7:0]  fifo_data;

  sfcs_fifo #(
    .WIDTH(`SFCS_FIFO_WIDTH),
    .DEPTH(`SFCS_FIFO_DEPTH)
  ) u_fifo (
    .i_clock    (i_clock),
    .i_rst      (i_rst),
    .i_in_valid (i_wr_valid),
    .i_in_data  (i_wr_data),
    .o_in_ready (o_wr_ready),
    .o_out_valid(fifo_valid),
    .o_out_data (fifo_data),
    .i_out_ready(fifo_pop)
  );

  // Opcode of the first byte; no signature read opcode exists here
  function automatic logic [7:0] opcode_for(sfcs_state_e s, logic boot, sfcs_op_e op);
    logic [7:0] r;
    r = `SFCS_LATCH_ENABLE_COMMAND;                                            // [R01] [R02] [R04]
    unique case (s)
      ST_POLL_WEL, ST_POLL_WIP: r = `SFCS_STATUS_FETCH_COMMAND;             // [R12]
      ST_MAIN: begin
        if (boot) begin
          r = `SFCS_STATUS_STORE_COMMAND;                                    // [R01] [R06]
        end else begin
          unique case (op)
            OP_READ:         r = `SFCS_FAST_READ_COMMAND;                    // [R05]
            OP_PROGRAM:      r = `SFCS_PAGE_PROGRAM_COMMAND;                 // [R07]
            OP_SECTOR_ERASE: r = `SFCS_SECTOR_ERASE_COMMAND;                 // [R08]
            OP_CHIP_ERASE:   r = `SFCS_CHIP_ERASE_COMMAND;                   // [R08]
          endcase
        end
      end
      ST_IDLE, ST_LATCH_ENABLE_COMMAND: r = `SFCS_LATCH_ENABLE_COMMAND;
    endcase
    return r;
  endfunction

  // Whole command length in bytes, select held low throughout
  function automatic logic [16:0] length_for(sfcs_state_e s, logic boot, sfcs_op_e op, logic [15:0] len);
    logic [16:0] r;
    r = 17'h00001;
    if (s == ST_POLL_WEL || s == ST_POLL_WIP || (s == ST_MAIN && boot)) begin
      r = 17'h00002;                                                         // [R06]
    end else if (s == ST_MAIN) begin
      unique case (op)
        OP_READ:         r = 17'(len) + 17'h00005;                           // [R05]
        OP_PROGRAM:      r = 17'(len) + 17'h00004;                           // [R07]
        OP_SECTOR_ERASE: r = 17'h00004;                                      // [R08]
        OP_CHIP_ERASE:   r = 17'h00001;                                      // [R08]
      endcase
    end
    return r;
  endfunction

  always_comb begin
    st_d       = st_q;
    op_d       = op_q;
    addr_d     = addr_q;
    len_d      = len_q;
    nbytes_d   = nbytes_q;
    byte_d     = byte_q;
    tx_d       = tx_q;
    rx_d       = rx_q;
    status_d   = status_q;
    half_d     = half_q;
    gap_d      = gap_q;
    bit_d      = bit_q;
    act_d      = act_q;
    sck_d      = sck_q;
    cs_d       = cs_q;
    boot_d     = boot_q;
    booted_d   = booted_q;
    ready_d    = ready_q;
    rd_data_d  = rd_data_q;
    rd_valid_d = 1'b0;
    start      = 1'b0;
    done       = 1'b0;
    fifo_pop   = 1'b0;
    byte_end   = 1'b0;
    nxt        = 17'(byte_q + 17'h00001);
    need_data  = st_q == ST_MAIN && !boot_q && op_q == OP_PROGRAM && nxt >= 17'h00004;
    nxt_byte   = `SFCS_DUMMY_BYTE;                                           // [R05]
    if (st_q == ST_MAIN && !boot_q && op_q != OP_CHIP_ERASE) begin
      unique case (nxt)
        17'h00001: nxt_byte = addr_q[23:16];                                 // [R05] [R07] [R08]
        17'h00002: nxt_byte = addr_q[15:8];
        17'h00003: nxt_byte = addr_q[7:0];
        default:   nxt_byte = need_data ? fifo_data : `SFCS_DUMMY_BYTE;      // [R07]
      endcase
    end else if (st_q == ST_MAIN && boot_q) begin
      nxt_byte = `SFCS_STATUS_CLEAR_VALUE;                                   // [R01] [R13]
    end
    // Mode 0: sample on rising edge, shift on falling edge, clock idles low
    if (act_q) begin
      if (half_q != HALF_LAST) begin
        half_d = 6'(half_q + 6'h01);
      end else if (!sck_q) begin
        sck_d  = 1'b1;
        rx_d   = {rx_q[6:0], sin_q};                                         // [R14]
        half_d = '0;
      end else if (bit_q != 3'h0) begin
        sck_d  = 1'b0;
        tx_d   = {tx_q[6:0], 1'b0};                                          // [R14]
        bit_d  = 3'(bit_q - 3'h1);
        half_d = '0;
      end else if (nxt == nbytes_q) begin
        sck_d    = 1'b0;
        cs_d     = 1'b1;                                                     // [R14]
        act_d    = 1'b0;
        gap_d    = GAP_LEN;
        half_d   = '0;
        byte_end = 1'b1;
      end else if (!(need_data && !fifo_valid)) begin
        // Program data stalls with the clock high until the FIFO has a byte
        sck_d    = 1'b0;
        bit_d    = 3'h7;
        byte_d   = nxt;
        tx_d     = nxt_byte;
        fifo_pop = need_data;                                                // [R07]
        half_d   = '0;
        byte_end = 1'b1;
      end
    end else if (gap_q != '0) begin
      gap_d = 5'(gap_q - 5'h01);
      done  = gap_q == 5'h01;
    end
    if (byte_end) begin
      if ((st_q == ST_POLL_WEL || st_q == ST_POLL_WIP) && byte_q == 17'h00001) begin
        status_d = rx_q;                                                     // [R12]
      end
      if (st_q == ST_MAIN && !boot_q && op_q == OP_READ && byte_q >= 17'h00005) begin
        rd_valid_d = 1'b1;                                                   // [R05]
        rd_data_d  = rx_q;
      end
    end
    unique case (st_q)
      ST_IDLE: begin
        if (!act_q && gap_q == '0) begin
          if (!booted_q && !boot_q) begin
            boot_d = 1'b1;                                                   // [R13]
            st_d   = ST_LATCH_ENABLE_COMMAND;                                                // [R01]
            start  = 1'b1;
          end else if (i_cmd_valid && ready_q) begin
            op_d    = sfcs_op_e'(i_cmd_op);
            addr_d  = i_cmd_addr;
            len_d   = i_cmd_len;
            ready_d = 1'b0;
            st_d    = (sfcs_op_e'(i_cmd_op) == OP_READ) ? ST_MAIN : ST_LATCH_ENABLE_COMMAND; // [R02] [R03]
            start   = 1'b1;
          end
        end
      end
      ST_LATCH_ENABLE_COMMAND: begin
        if (done) begin
          st_d  = ST_POLL_WEL;
          start = 1'b1;
        end
      end
      ST_POLL_WEL: begin
        if (done) begin
          st_d  = status_q[`SFCS_WRITE_LATCH_FLAG_BIT] ? ST_MAIN : ST_POLL_WEL; // [R01] [R02] [R12]
          start = 1'b1;
        end
      end
      ST_MAIN: begin
        if (done && !boot_q && op_q == OP_READ) begin
          st_d    = ST_IDLE;
          ready_d = 1'b1;
        end else if (done) begin
          st_d  = ST_POLL_WIP;                                               // [R15]
          start = 1'b1;
        end
      end
      ST_POLL_WIP: begin
        if (done && !status_q[`SFCS_WRITE_PENDING_FLAG_BIT]) begin
          st_d     = ST_IDLE;                                                // [R15]
          boot_d   = 1'b0;
          booted_d = 1'b1;
          ready_d  = 1'b1;
        end else if (done) begin
          start = 1'b1;
        end
      end
    endcase
    if (start) begin
      act_d    = 1'b1;
      cs_d     = 1'b0;                                                       // [R14]
      sck_d    = 1'b0;
      half_d   = '0;
      bit_d    = 3'h7;
      byte_d   = '0;
      tx_d     = opcode_for(st_d, boot_d, op_d);
      nbytes_d = length_for(st_d, boot_d, op_d, len_d);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_q <= ST_IDLE; op_q <= OP_READ; addr_q <= '0; len_q <= '0;
      nbytes_q <= '0; byte_q <= '0; tx_q <= '0; rx_q <= '0; status_q <= '0;
      half_q <= '0; gap_q <= '0; bit_q <= '0; act_q <= 1'b0; sck_q <= 1'b0;
      cs_q <= 1'b1; oe_q <= 1'b0; boot_q <= 1'b0; booted_q <= 1'b0;
      ready_q <= 1'b0; rd_data_q <= '0; rd_valid_q <= 1'b0;
      sin_meta_q <= 1'b0; sin_q <= 1'b0;
    end else begin
      st_q <= st_d; op_q <= op_d; addr_q <= addr_d; len_q <= len_d;
      nbytes_q <= nbytes_d; byte_q <= byte_d; tx_q <= tx_d; rx_q <= rx_d; status_q <= status_d;
      half_q <= half_d; gap_q <= gap_d; bit_q <= bit_d; act_q <= act_d; sck_q <= sck_d;
      cs_q <= cs_d; oe_q <= 1'b1; boot_q <= boot_d; booted_q <= booted_d;   // [R10] [R11]
      ready_q <= ready_d; rd_data_q <= rd_data_d; rd_valid_q <= rd_valid_d;
      sin_meta_q <= i_flash_serial_in; sin_q <= sin_meta_q;
    end
  end

  assign o_cmd_ready              = ready_q;
  assign o_boot_done              = booted_q;
  assign o_rd_valid               = rd_valid_q;
  assign o_rd_data                = rd_data_q;
  assign o_flash_serial_clock     = sck_q;
  assign o_flash_serial_clock_oe  = oe_q;                                    // [R10]
  assign o_flash_serial_out       = tx_q[7];                                 // [R14]
  assign o_flash_serial_out_oe    = oe_q;
  assign o_flash_select_n         = cs_q;
  assign o_flash_select_n_oe      = oe_q;
  assign o_second_device_select_n = 1'b1;                                    // [R09] [R10]

  property p_release_floating;
    @(posedge i_clock) disable iff (i_rst)
      $past(i_rst) |-> !o_flash_select_n_oe && !o_flash_serial_clock_oe && !o_flash_serial_out_oe;
  endproperty
  a_release_floating: assert property (p_release_floating) else $error("flash pins driven during reset"); // [R10]

  property p_idle_clock_low;
    @(posedge i_clock) disable iff (i_rst) o_flash_select_n |-> !o_flash_serial_clock;
  endproperty
  a_idle_clock_low: assert property (p_idle_clock_low) else $error("serial clock high while deselected"); // [R14]

  property p_clock_high_width;
    @(posedge i_clock) disable iff (i_rst) $rose(o_flash_serial_clock) |-> o_flash_serial_clock [*8];
  endproperty
  a_clock_high_width: assert property (p_clock_high_width) else $error("serial clock high phase too short"); // [R14]

  property p_latch_before_write;
    @(posedge i_clock) disable iff (i_rst)
      (start && st_d == ST_MAIN && !(op_d == OP_READ && !boot_d)) |-> status_q[1] && st_q == ST_POLL_WEL;
  endproperty
  a_latch_before_write: assert property (p_latch_before_write) else $error("write without latch flag"); // [R02]

  property p_boot_store_zero;
    @(posedge i_clock) disable iff (i_rst)
      (start && boot_d && st_d == ST_MAIN) |=> tx_q == 8'h01 && nbytes_q == 17'h00002;
  endproperty
  a_boot_store_zero: assert property (p_boot_store_zero) else $error("boot status store malformed"); // [R01]

  property p_boot_begins_enable;
    @(posedge i_clock) disable iff (i_rst)
      $past(i_rst) |=> o_flash_serial_out == 1'b0 && !o_flash_select_n ##0 tx_q == 8'h06;
  endproperty
  a_boot_begins_enable: assert property (p_boot_begins_enable) else $error("boot does not open with enable"); // [R13]

  property p_no_signature;
    @(posedge i_clock) disable iff (i_rst) (act_q && byte_q == '0) |-> tx_q != 8'h9f && tx_q != 8'hab;
  endproperty
  a_no_signature: assert property (p_no_signature) else $error("signature opcode sent"); // [R04]

  property p_ready_after_idle_flash;
    @(posedge i_clock) disable iff (i_rst) $rose(o_cmd_ready) |-> !status_q[0] || $past(st_q) == ST_MAIN;
  endproperty
  a_ready_after_idle_flash: assert property (p_ready_after_idle_flash) else $error("ready while flash busy"); // [R15]

  property p_read_header;
    @(posedge i_clock) disable iff (i_rst)
      (start && st_d == ST_MAIN && !boot_d && op_d == OP_READ) |=> nbytes_q == 17'(len_q) + 17'h00005;
  endproperty
  a_read_header: assert property (p_read_header) else $error("fast read length wrong"); // [R05]
endmodule
`default_nettype wire

/* File: sfcs_flash_model.sv */
// Purpose: Behavioural serial NOR flash on the sequencer's SPI pins.
// Assumes: SPI mode 0, MSB first, whole bytes per frame.
// Notes:   Latch and busy flags lag by parameter polls; faults count in errors.
`timescale 1ns/1ns
`default_nettype none
module sfcs_flash_model #(
  parameter int WEL_DELAY  = 1,
  parameter int BUSY_POLLS = 2
) (
  input  wire logic i_sck,
  input  wire logic i_mosi,
  input  wire logic i_cs_n,
  output logic      o_miso
);
  logic [7:0]  frame_q[$];
  logic [7:0]  prog_q[$];
  logic [31:0] log_q[$];
  logic [7:0]  in_sh  = 8'h00;
  logic [7:0]  out_sh = 8'h00;
  logic        write_latch_flag    = 1'b0;
  int          nbit   = 0;
  int          wel_wait = 0;
  int          busy   = 0;
  int          errors = 0;

  initial o_miso = 1'b0;

  function automatic logic [7:0] next_byte();
    logic [23:0] a;
    if (frame_q[0] == 8'h05)
      return {6'h00, write_latch_flag && (wel_wait == 0), busy > 0};
    if (frame_q[0] == 8'h0b && frame_q.size() >= 5) begin
      a = {frame_q[1], frame_q[2], frame_q[3]} + 24'(frame_q.size() - 5);
      return a[7:0] ^ 8'h5a;
    end
    return {8{~o_miso}};
  endfunction

  // Repeated polls are logged once so the bench sees one entry per poll run
  task automatic finish_frame();
    logic [7:0] op;
    int         n;
    op = frame_q[0];
    n = frame_q.size();
    if (!(op == 8'h05 && log_q.size() > 0 && log_q[$][31:24] == 8'h05))
      log_q.push_back({op, n >= 4 ? {frame_q[1], frame_q[2], frame_q[3]} : 24'h000000});
    if (busy > 0 && op != 8'h05) errors++;
    case (op)
      8'h06: begin
        write_latch_flag = 1'b1;
        wel_wait = WEL_DELAY;
      end
      8'h05: begin
        if (wel_wait > 0) wel_wait--;
        if (busy > 0) busy--;
      end
      8'h01: begin
        if (n != 2 || frame_q[1] != 8'h00 || !write_latch_flag) errors++;
        write_latch_flag = 1'b0;
        busy = BUSY_POLLS;
      end
      8'h02, 8'h20, 8'hc7: begin
        if (!write_latch_flag || wel_wait != 0) errors++;
        if ((op == 8'h20 && n != 4) || (op == 8'hc7 && n != 1) || (op == 8'h02 && n < 5)) errors++;
        for (int i = 4; op == 8'h02 && i < n; i++) prog_q.push_back(frame_q[i]);
        write_latch_flag = 1'b0;
        busy = BUSY_POLLS;
      end
      8'h0b: if (n < 5) errors++;
      default: errors++;
    endcase
  endtask

  always @(posedge i_sck) begin
    if (!i_cs_n) begin
      in_sh = {in_sh[6:0], i_mosi};
      nbit++;
      if (nbit == 8) begin
        frame_q.push_back(in_sh);
        nbit = 0;
        out_sh = next_byte();
      end
    end
  end

  always @(negedge i_sck) begin
    if (!i_cs_n) begin
      o_miso = out_sh[7];
      out_sh = {out_sh[6:0], 1'b0};
    end
  end

  // A frame cut off mid-byte is dropped, as a real part aborts it
  always @(posedge i_cs_n) begin
    o_miso = ~o_miso;
    if (frame_q.size() > 0 && nbit == 0) finish_frame();
    frame_q.delete();
    nbit = 0;
  end

  always @(negedge i_cs_n) if (i_sck !== 1'b0) errors++;
endmodule
`default_nettype wire

/* File: spi_flash_command_sequencer_tb.sv */
// Purpose: Self-checking bench of the flash command sequencer.
// Assumes: Flash model on the resolved SPI wires, slow latch and busy answers.
// Notes:   Table rows cover the four commands; fill, long page and reset follow.
`timescale 1ns/1ns
`default_nettype none
`define CHECK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module spi_flash_command_sequencer_tb;
  import sfcs_pkg::*;
  typedef struct packed {sfcs_op_e op; logic [7:0] code; logic [23:0] addr; logic [15:0] len;} sfcs_row_s;
  logic i_clock = 1'b0, i_rst = 1'b1, i_cmd_valid = 1'b0, i_wr_valid = 1'b0, last_mosi = 1'b0;
  logic [1:0] i_cmd_op = 2'h0;
  logic [23:0] i_cmd_addr = 24'h000000;
  logic [15:0] i_cmd_len = 16'h0000;
  logic [7:0] i_wr_data = 8'h00, o_rd_data, b;
  logic o_cmd_ready, o_boot_done, o_wr_ready, o_rd_valid, i_flash_serial_in, o_second_device_select_n;
  logic o_flash_serial_clock, o_flash_serial_clock_oe, o_flash_serial_out, o_flash_serial_out_oe;
  logic o_flash_select_n, o_flash_select_n_oe;
  wire sck_w  = o_flash_serial_clock_oe ? o_flash_serial_clock : 1'b0;
  wire cs_w   = o_flash_select_n_oe ? o_flash_select_n : 1'b1;
  wire mosi_w = o_flash_serial_out_oe ? o_flash_serial_out : ~last_mosi;
  int fail_count = 0, samples_checked = 0;
  logic [7:0] rd_q[$];
  sfcs_row_s rows [4] = '{'{OP_READ, 8'h0b, 24'h123456, 16'h0004}, '{OP_PROGRAM, 8'h02, 24'h000100, 16'h0003},
                         '{OP_SECTOR_ERASE, 8'h20, 24'h00a000, 16'h0000}, '{OP_CHIP_ERASE, 8'hc7, 24'h0, 16'h0}};
  sfcs_row_s r;

  sfcs_sequencer sfcs_sequencer_i (.i_clock, .i_rst, .i_cmd_valid, .i_cmd_op, .i_cmd_addr, .i_cmd_len,
    .o_cmd_ready, .o_boot_done, .i_wr_valid, .i_wr_data, .o_wr_ready, .o_rd_valid, .o_rd_data,
    .o_flash_serial_clock, .o_flash_serial_clock_oe, .o_flash_serial_out, .o_flash_serial_out_oe,
    .o_flash_select_n, .o_flash_select_n_oe, .o_second_device_select_n, .i_flash_serial_in);
  sfcs_flash_model #(.WEL_DELAY(1), .BUSY_POLLS(2)) sfcs_flash_model_i (.i_sck(sck_w), .i_mosi(mosi_w),
    .i_cs_n(cs_w), .o_miso(i_flash_serial_in));

  always #5 i_clock = ~i_clock;
  always @(posedge i_clock) if (o_flash_serial_out_oe === 1'b1) last_mosi <= o_flash_serial_out;
  always @(posedge i_clock) if (o_rd_valid === 1'b1) rd_q.push_back(o_rd_data);

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wait_ready();
    int t;
    t = 0;
    do begin
      @(negedge i_clock);
      t++;
    end while (o_cmd_ready !== 1'b1 && t < 40000);
    if (o_cmd_ready !== 1'b1) fail_count++;
    @(posedge i_clock);
  endtask

  // Valid and data stand until an edge at which the buffer is seen ready
  task automatic push(input logic [7:0] d);
    @(posedge i_clock);
    i_wr_valid <= 1'b1;
    i_wr_data <= d;
    do @(posedge i_clock); while (o_wr_ready !== 1'b1);
    i_wr_valid <= 1'b0;
  endtask

  task automatic start(input sfcs_row_s c);
    wait_ready();
    i_cmd_valid <= 1'b1;
    i_cmd_op <= c.op;
    i_cmd_addr <= c.addr;
    i_cmd_len <= c.len;
    @(posedge i_clock);
    i_cmd_valid <= 1'b0;
    repeat (2) @(posedge i_clock);
  endtask

  task automatic expect_ops(input logic [7:0] exp[$], input logic [23:0] a);
    logic [31:0] e;
    foreach (exp[i]) begin
      e = sfcs_flash_model_i.log_q.size() > 0 ? sfcs_flash_model_i.log_q.pop_front() : 32'hffffffff;
      `CHECK(e[31:24], exp[i])
      if (exp[i] inside {8'h0b, 8'h02, 8'h20}) `CHECK(e[23:0], a)
    end
  endtask

  task automatic check_cmd(input sfcs_row_s c, input logic [7:0] base);
    logic [23:0] a;
    if (c.op == OP_READ) expect_ops('{8'h0b}, c.addr);
    else expect_ops('{8'h06, 8'h05, c.code, 8'h05}, c.addr);
    for (int i = 0; i < c.len; i++) begin
      a = c.addr + 24'(i);
      if (c.op == OP_READ) begin
        b = rd_q.size() > 0 ? rd_q.pop_front() : 8'hxx;
        `CHECK(b, a[7:0] ^ 8'h5a)
      end else begin
        b = sfcs_flash_model_i.prog_q.size() > 0 ? sfcs_flash_model_i.prog_q.pop_front() : 8'hxx;
        `CHECK(b, base + 8'(i))
      end
    end
  endtask

  initial begin
    repeat (10) @(posedge i_clock);
    @(negedge i_clock);
    `CHECK({o_flash_serial_clock_oe, o_flash_serial_out_oe, o_flash_select_n_oe, o_second_device_select_n}, 4'h1)
    @(posedge i_clock);
    i_rst <= 1'b0;
    wait_ready();
    `CHECK(o_boot_done, 1'b1)
    `CHECK({o_flash_serial_clock_oe, o_flash_serial_out_oe, o_flash_select_n_oe}, 3'h7)
    expect_ops('{8'h06, 8'h05, 8'h01, 8'h05}, 24'h0);
    foreach (rows[k]) begin
      for (int i = 0; rows[k].op == OP_PROGRAM && i < rows[k].len; i++) push(8'h30 + 8'(i));
      start(rows[k]);
      wait_ready();
      check_cmd(rows[k], 8'h30);
    end
    // Fill the buffer until it refuses, then a page longer than the buffer
    for (int i = 0; i < 32; i++) push(8'h80 + 8'(i));
    @(negedge i_clock);
    `CHECK(o_wr_ready, 1'b0)
    r = '{OP_PROGRAM, 8'h02, 24'h000200, 16'h0022};
    start(r);
    for (int i = 32; i < 34; i++) push(8'h80 + 8'(i));
    wait_ready();
    check_cmd(r, 8'h80);
    `CHECK(o_wr_ready, 1'b1)
    // Reset in mid-read: pins float, then boot repeats the protection clearing
    r = '{OP_READ, 8'h0b, 24'h000010, 16'h0064};
    start(r);
    repeat (1500) @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (10) @(posedge i_clock);
    @(negedge i_clock);
    `CHECK({o_flash_serial_clock_oe, o_flash_serial_out_oe, o_flash_select_n_oe, o_second_device_select_n}, 4'h1)
    @(posedge i_clock);
    i_rst <= 1'b0;
    rd_q.delete();
    sfcs_flash_model_i.log_q.delete();
    wait_ready();
    expect_ops('{8'h06, 8'h05, 8'h01, 8'h05}, 24'h0);
    `CHECK(sfcs_flash_model_i.errors, 0)
    report_and_stop();
  end

  initial begin
    // About 77k cycles expected; the limit at 90k cycles leaves a margin above that
    #900000;
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
